// file: shared/fls_params.svh
`ifndef FLS_PARAMS_SVH
`define FLS_PARAMS_SVH
// Command codes.
`define FLS_OP 8'h01
`define FLS_CLRF 8'h03
`define FLS_OC 8'h46
`define FLS_UC 8'h4b
`define FLS_OTF 8'h4f
`define FLS_OTR 8'h50
`define FLS_OTW 8'h51
`define FLS_UTW 8'h52
`define FLS_UTF 8'h53
`define FLS_UTR 8'h54
`define FLS_VOF 8'h55
`define FLS_VOR 8'h56
`define FLS_VOW 8'h57
`define FLS_SBYTE 8'h78
`define FLS_SWORD 8'h79
`define FLS_SIN 8'h7c
`define FLS_STEMP 8'h7d
// Reset values.
`define FLS_OP_RST 8'h80
`define FLS_OC_RST 16'hdbc0
`define FLS_UC_RST 16'hdc3f
`define FLS_OTF_RST 16'hebe8
`define FLS_OTW_RST 16'heb70
`define FLS_UTW_RST 16'hdc40
`define FLS_UTF_RST 16'he530
`define FLS_VOF_RST 16'hd3a0
`define FLS_VOW_RST 16'hd34d
`define FLS_RSP_RST 8'h80
// Field positions and response field codes.
`define FLS_OP_ON 7
`define FLS_SW_CATCH 0
`define FLS_SW_TEMP 2
`define FLS_SW_OFF 6
`define FLS_SW_INPUT 13
`define FLS_ST_OTF 7
`define FLS_ST_OTW 6
`define FLS_ST_UTW 5
`define FLS_ST_UTF 4
`define FLS_SI_OVF 7
`define FLS_SI_OVW 6
`define FLS_RSP_SHUT 2'h2
`define FLS_RTY_ALL 3'h7
// Timing and number format.
`define FLS_CLK_NS 50
`define FLS_STEP_NS 35000000
`define FLS_FRAC 4
`endif

// file: shared/fls_pkg.sv
package fls_pkg;
    typedef struct packed {
        logic [7:0] code;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } fls_cmd_t;
    typedef struct packed {
        logic signed [15:0] temp;
        logic signed [15:0] vin;
    } fls_meas_t;
    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_HOLD, ST_WAIT} fls_state_t;
endpackage

// file: core/fls_supervisor.sv
`timescale 1ns/1ps
`include "fls_params.svh"
module fls_supervisor #(
    parameter int unsigned STEP_CYC = `FLS_STEP_NS / `FLS_CLK_NS,
    parameter logic signed [31:0] RIPPLE = 32'sh0000_0050
) (
    input wire logic CLK_SYS, // System clock, 20 MHz.
    input wire logic RSTN, // Asynchronous reset, active low.
    input wire fls_pkg::fls_cmd_t CMD, // Command from the serial engine.
    input wire fls_pkg::fls_meas_t MEAS, // Temperature and input voltage.
    input wire logic CTRL_PIN, // Enable pin, asynchronous.
    output logic [15:0] RDATA, // Read answer.
    output logic RVALID, // Read answer strobe.
    output logic CMD_ERR, // Unmapped read strobe.
    output logic PWR_EN, // Output stage enable.
    output logic ALERT_O, // Alert pin drive level.
    output logic ALERT_OE, // Alert pin pulled low when high.
    output logic signed [31:0] OC_PEAK_LIM, // Peak inductor limit.
    output logic signed [31:0] UC_VALLEY_LIM // Valley inductor limit.
);
    import fls_pkg::*;

    // Limit word to fixed point with FLS_FRAC fraction bits.
    function automatic logic signed [31:0] lin_dec(input logic [15:0] v);
        logic signed [5:0] sh;
        logic signed [31:0] m;
        sh = $signed({v[15], v[15:11]}) + 6'sd`FLS_FRAC;
        m = {{21{v[10]}}, v[10:0]};
        if (sh >= 0) begin
            lin_dec = m <<< sh[4:0];
        end else begin
            lin_dec = m >>> 5'(-sh);
        end
    endfunction

    logic [7:0] op_reg, otr_reg, utr_reg, vor_reg;
    logic [15:0] oc_reg, uc_reg, otf_reg, otw_reg, utw_reg, utf_reg, vof_reg, vow_reg;
    logic [7:0] stemp_reg, sin_reg;
    logic ctl_s1, ctl_s2;
    logic otf_q, utf_q, vof_q;
    logic [2:0] flt_d;
    fls_state_t state, state_next;
    logic [23:0] cyc_cnt;
    logic [3:0] step_n;
    logic clr;

    // Enable pin synchroniser.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ctl_s1 <= 1'b0;
            ctl_s2 <= 1'b0;
        end else begin
            ctl_s1 <= CTRL_PIN;
            ctl_s2 <= ctl_s1;
        end
    end

    // Host writes to limits, responses and the on/off command.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            op_reg <= `FLS_OP_RST;
            oc_reg <= `FLS_OC_RST;
            uc_reg <= `FLS_UC_RST;
            otf_reg <= `FLS_OTF_RST;
            otw_reg <= `FLS_OTW_RST;
            utw_reg <= `FLS_UTW_RST;
            utf_reg <= `FLS_UTF_RST;
            vof_reg <= `FLS_VOF_RST;
            vow_reg <= `FLS_VOW_RST;
            otr_reg <= `FLS_RSP_RST;
            utr_reg <= `FLS_RSP_RST;
            vor_reg <= `FLS_RSP_RST;
        end else if (CMD.wr) begin
            case (CMD.code)
                `FLS_OP: op_reg <= CMD.wdata[7:0];
                `FLS_OC: oc_reg <= CMD.wdata;
                `FLS_UC: uc_reg <= CMD.wdata;
                `FLS_OTF: otf_reg <= CMD.wdata;
                `FLS_OTR: otr_reg <= CMD.wdata[7:0];
                `FLS_OTW: otw_reg <= CMD.wdata;
                `FLS_UTW: utw_reg <= CMD.wdata;
                `FLS_UTF: utf_reg <= CMD.wdata;
                `FLS_UTR: utr_reg <= CMD.wdata[7:0];
                `FLS_VOF: vof_reg <= CMD.wdata;
                `FLS_VOR: vor_reg <= CMD.wdata[7:0];
                `FLS_VOW: vow_reg <= CMD.wdata;
                default: ;
            endcase
        end
    end

    logic signed [31:0] t_fix, v_fix;
    logic signed [31:0] otf_fix, otw_fix, utf_fix, utw_fix, vof_fix, vow_fix;
    logic ot_w, ut_w, vo_w, otf_set, utf_set, vof_set;
    // Decoded limits and comparisons against the measurements.
    always_comb begin
        t_fix = {{16{MEAS.temp[15]}}, MEAS.temp};
        v_fix = {{16{MEAS.vin[15]}}, MEAS.vin};
        otf_fix = lin_dec(otf_reg);
        otw_fix = lin_dec(otw_reg);
        utf_fix = lin_dec(utf_reg);
        utw_fix = lin_dec(utw_reg);
        vof_fix = lin_dec(vof_reg);
        vow_fix = lin_dec(vow_reg);
        ot_w = t_fix > otw_fix;
        ut_w = t_fix < utw_fix;
        vo_w = v_fix > vow_fix;
        otf_set = t_fix > otf_fix;
        utf_set = t_fix < utf_fix;
        vof_set = v_fix > vof_fix;
    end

    // Hot and cold fault levels with hysteresis back to the warning limits; the supply fault follows its limit directly.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            otf_q <= 1'b0;
            utf_q <= 1'b0;
            vof_q <= 1'b0;
            flt_d <= 3'h0;
        end else begin
            otf_q <= otf_set | (otf_q & (t_fix >= otw_fix));
            utf_q <= utf_set | (utf_q & (t_fix <= utw_fix));
            vof_q <= vof_set;
            flt_d <= {otf_q, utf_q, vof_q};
        end
    end

    // Sticky status; a new event wins over a clear in the same cycle.
    assign clr = CMD.wr && (CMD.code == `FLS_CLRF);
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            stemp_reg <= 8'h00;
            sin_reg <= 8'h00;
        end else begin
            stemp_reg <= (clr ? 8'h00 : stemp_reg)
                | {otf_q, ot_w, ut_w, utf_q, 4'h0};
            sin_reg <= (clr ? 8'h00 : sin_reg)
                | {vof_q, vo_w, 6'h00};
        end
    end

    logic [15:0] sword;
    // Summary word built from the detail registers and the output enable.
    always_comb begin
        sword = 16'h0000;
        sword[`FLS_SW_TEMP] = |stemp_reg;
        sword[`FLS_SW_INPUT] = |sin_reg;
        sword[`FLS_SW_CATCH] = sin_reg[`FLS_SI_OVW];
        sword[`FLS_SW_OFF] = ~PWR_EN;
    end

    // Register read port and unmapped-code flag.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= 16'h0000;
            RVALID <= 1'b0;
            CMD_ERR <= 1'b0;
        end else begin
            RVALID <= CMD.rd;
            CMD_ERR <= 1'b0;
            if (CMD.rd) begin
                case (CMD.code)
                    `FLS_OP: RDATA <= {8'h00, op_reg};
                    `FLS_OC: RDATA <= oc_reg;
                    `FLS_UC: RDATA <= uc_reg;
                    `FLS_OTF: RDATA <= otf_reg;
                    `FLS_OTR: RDATA <= {8'h00, otr_reg};
                    `FLS_OTW: RDATA <= otw_reg;
                    `FLS_UTW: RDATA <= utw_reg;
                    `FLS_UTF: RDATA <= utf_reg;
                    `FLS_UTR: RDATA <= {8'h00, utr_reg};
                    `FLS_VOF: RDATA <= vof_reg;
                    `FLS_VOR: RDATA <= {8'h00, vor_reg};
                    `FLS_VOW: RDATA <= vow_reg;
                    `FLS_SBYTE: RDATA <= {8'h00, sword[7:0]};
                    `FLS_SWORD: RDATA <= sword;
                    `FLS_SIN: RDATA <= {8'h00, sin_reg};
                    `FLS_STEMP: RDATA <= {8'h00, stemp_reg};
                    default: begin
                        RDATA <= 16'h0000;
                        CMD_ERR <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Derived inductor limits and host alert.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            OC_PEAK_LIM <= 32'sh0;
            UC_VALLEY_LIM <= 32'sh0;
            ALERT_OE <= 1'b0;
        end else begin
            OC_PEAK_LIM <= lin_dec(oc_reg) + RIPPLE;
            UC_VALLEY_LIM <= lin_dec(uc_reg) - RIPPLE;
            ALERT_OE <= |{stemp_reg, sin_reg};
        end
    end
    assign ALERT_O = 1'b0;

    logic on_req, evt, shut, rtry, cnt_rst, step_p;
    logic [7:0] rsp;
    logic [2:0] rsp_dly;
    logic [2:0] fnew;
    // Response selection: a standing fault shuts a running output again, while a wait reacts only to new faults.
    always_comb begin
        on_req = ctl_s2 & op_reg[`FLS_OP_ON];
        fnew = {otf_q, utf_q, vof_q} & ((state == ST_RUN) ? 3'h7 : ~flt_d);
        evt = |fnew;
        if (fnew[2]) begin
            rsp = otr_reg;
        end else if (fnew[1]) begin
            rsp = utr_reg;
        end else begin
            rsp = vor_reg;
        end
        shut = evt && (rsp[7:6] == `FLS_RSP_SHUT);
        rtry = rsp[5:3] == `FLS_RTY_ALL;
    end

    // Output control state machine.
    always_comb begin
        state_next = state;
        case (state)
            ST_OFF: begin
                if (on_req && !(otf_q | utf_q | vof_q)) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN, ST_WAIT: begin
                if (!on_req) begin
                    state_next = ST_OFF;
                end else if (shut) begin
                    state_next = rtry ? ST_WAIT : ST_HOLD;
                end else if (state == ST_WAIT && step_n == {1'b0, rsp_dly} + 4'h1) begin
                    state_next = ST_RUN;
                end
            end
            ST_HOLD: begin
                if (!on_req) begin
                    state_next = ST_OFF;
                end else if (!(otf_q | utf_q | vof_q)) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_OFF;
        endcase
    end

    logic [2:0] dly_reg;
    // Delay of the fault that started the current wait.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            dly_reg <= 3'h0;
        end else if (shut) begin
            dly_reg <= rsp[2:0];
        end
    end
    assign rsp_dly = dly_reg;

    // State register and output enable.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state <= ST_OFF;
            PWR_EN <= 1'b0;
        end else begin
            state <= state_next;
            PWR_EN <= state_next == ST_RUN;
        end
    end

    // Retry timer: 35 ms step pulses counted up to delay plus one.
    assign cnt_rst = shut || state != ST_WAIT || !on_req;
    assign step_p = cyc_cnt == 24'(STEP_CYC - 1);
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cyc_cnt <= 24'h0;
            step_n <= 4'h0;
        end else if (cnt_rst) begin
            cyc_cnt <= 24'h0;
            step_n <= 4'h0;
        end else if (step_p) begin
            cyc_cnt <= 24'h0;
            step_n <= step_n + 4'h1;
        end else begin
            cyc_cnt <= cyc_cnt + 24'h1;
        end
    end

    a_hot_hyst: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        otf_q && t_fix >= otw_fix |=> otf_q) else $error("Hot fault released above warning.");
    a_cold_hyst: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        utf_q && t_fix <= utw_fix |=> utf_q) else $error("Cold fault released below warning.");
    a_hot_fault_set: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        t_fix > otf_fix |=> otf_q) else $error("Hot fault not declared.");
    a_hot_warn_stat: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        ot_w |=> stemp_reg[`FLS_ST_OTW] && sword[`FLS_SW_TEMP] ##1 ALERT_OE)
        else $error("Hot warning not reported.");
    a_cold_warn_stat: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        ut_w |=> stemp_reg[`FLS_ST_UTW] ##1 ALERT_OE) else $error("Cold warning not reported.");
    a_supply_warn_stat: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        vo_w |=> sword[`FLS_SW_INPUT] && sword[`FLS_SW_CATCH]) else $error("Supply warning not reported.");
    a_hold_stays_off: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        state == ST_HOLD && on_req && (otf_q | utf_q | vof_q) |=> !PWR_EN && state == ST_HOLD)
        else $error("Output left hold while fault active.");
    a_retry_enter: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        state == ST_RUN && on_req && shut && rtry |=> state == ST_WAIT && !PWR_EN)
        else $error("Retry wait not entered.");
    a_retry_spacing: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        state == ST_WAIT && state_next == ST_RUN |-> step_n == {1'b0, dly_reg} + 4'h1 && step_n != 4'h0)
        else $error("Restart before retry delay elapsed.");
    a_retry_abandon: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        state == ST_WAIT && !on_req |=> state == ST_OFF && step_n == 4'h0)
        else $error("Pending retry not abandoned.");
    a_peak_limit: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        1'b1 |=> OC_PEAK_LIM == lin_dec($past(oc_reg)) + RIPPLE) else $error("Peak limit wrong.");
endmodule

// file: testbench/fls_host.sv
`timescale 1ns/1ps
// Host on the management bus: one command per call, read answers collected.
module fls_host (
    input wire logic clk, // System clock.
    output fls_pkg::fls_cmd_t cmd, // Command toward the supervisor.
    input wire logic [15:0] rdata, // Read answer.
    input wire logic rvalid, // Read answer strobe.
    input wire logic cmd_err // Unmapped read strobe.
);
    import fls_pkg::*;
    // Idle with both strobes low from time zero.
    initial begin
        cmd = '{code: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 16'h0000};
    end
    // A write lasts one cycle; the fields are then scrambled so stale data never looks valid.
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk);
        cmd <= '{code: c, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk);
        cmd <= '{code: ~c, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
    // A read takes its answer in the cycle after the request edge.
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic e, output logic ok);
        @(negedge clk);
        cmd <= '{code: c, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        @(negedge clk);
        cmd <= '{code: ~c, wr: 1'b0, rd: 1'b0, wdata: 16'hffff};
        d = rdata;
        e = cmd_err;
        ok = rvalid;
    endtask
endmodule

// file: testbench/fls_supervisor_test.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end
module fls_supervisor_test;
    import fls_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic ctrl_pin = 1'b1;
    fls_meas_t meas = '{temp: 16'sd400, vin: 16'sd192};
    fls_cmd_t cmd;
    logic [15:0] rdata;
    logic rvalid, cmd_err, pwr_en, alert_o, alert_oe;
    logic signed [31:0] oc_peak, uc_valley;
    int failures = 0;
    int checked = 0;
    logic [7:0] reg_code [11] = '{8'h46, 8'h4b, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57};
    logic [15:0] reg_rst [11] = '{16'hdbc0, 16'hdc3f, 16'hebe8, 16'h0080, 16'heb70, 16'hdc40,
        16'he530, 16'h0080, 16'hd3a0, 16'h0080, 16'hd34d};

    // Clock of 50 ns period.
    always #25 clk_sys = ~clk_sys;

    fls_supervisor #(.STEP_CYC(10)) fls_supervisor_i (.CLK_SYS(clk_sys), .RSTN(rstn), .CMD(cmd), .MEAS(meas),
        .CTRL_PIN(ctrl_pin), .RDATA(rdata), .RVALID(rvalid), .CMD_ERR(cmd_err), .PWR_EN(pwr_en),
        .ALERT_O(alert_o), .ALERT_OE(alert_oe), .OC_PEAK_LIM(oc_peak), .UC_VALLEY_LIM(uc_valley));
    fls_host fls_host_i (.clk(clk_sys), .cmd(cmd), .rdata(rdata), .rvalid(rvalid), .cmd_err(cmd_err));

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Reads one register and compares it, including the answer strobe.
    task automatic expect_rd(input logic [7:0] c, input logic [15:0] exp, input string what);
        logic [15:0] d;
        logic e, ok;
        fls_host_i.rd(c, d, e, ok);
        `CHK(what, 1'b1, ok)
        `CHK(what, 1'b0, e)
        `CHK(what, exp, d)
    endtask
    // Waits a bounded time for the output enable to reach a level.
    task automatic wait_pwr(input logic lvl, input int bound, input string what);
        int n;
        n = 0;
        while (pwr_en !== lvl && n < bound) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK(what, lvl, pwr_en)
        if (pwr_en !== lvl) final_report();
    endtask
    // Checks that the output stays disabled for a number of cycles.
    task automatic hold_off(input int n, input string what);
        int bad;
        bad = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (pwr_en !== 1'b0) bad++;
        end
        `CHK(what, 0, bad)
    endtask
    // Sets the measurements, counts of 1/16, and lets the status settle.
    task automatic set_meas(input logic signed [15:0] t, input logic signed [15:0] v);
        @(negedge clk_sys);
        meas = '{temp: t, vin: v};
        repeat (4) @(negedge clk_sys);
    endtask
    // Clears the sticky status and waits for the alert to follow.
    task automatic clear();
        fls_host_i.wr(8'h03, 16'h0000);
        repeat (3) @(negedge clk_sys);
    endtask

    // Reset values, derived limits and an unmapped read.
    task automatic t_defaults();
        logic [15:0] d;
        logic e, ok;
        for (int i = 0; i < 11; i++) expect_rd(reg_code[i], reg_rst[i], "reset value");
        `CHK("peak limit", 32'sd560, oc_peak)
        `CHK("valley limit", 1'b1, uc_valley inside {-32'sd561, -32'sd560})
        fls_host_i.rd(8'hee, d, e, ok);
        `CHK("unmapped flag", 1'b1, e)
        `CHK("unmapped data", 16'h0000, d)
    endtask
    // Every limit register takes a full word; the response registers are byte registers and keep only the low byte.
    task automatic t_rw();
        logic [15:0] p;
        for (int i = 0; i < 11; i++) begin
            p = 16'h5a00 | 16'(i);
            fls_host_i.wr(reg_code[i], p);
            expect_rd(reg_code[i], reg_rst[i][15:8] == 8'h00 ? {8'h00, p[7:0]} : p, "write back");
        end
        for (int i = 0; i < 11; i++) fls_host_i.wr(reg_code[i], reg_rst[i]);
        set_meas(16'sd400, 16'sd192);
        clear();
        wait_pwr(1'b1, 40, "restore");
    endtask
    // A hot warning reports and alerts without turning the output off.
    task automatic t_hot_warn();
        set_meas(16'sd1800, 16'sd192);
        expect_rd(8'h7d, 16'h0040, "hot warn status");
        expect_rd(8'h79, 16'h0004, "hot warn summary");
        `CHK("hot warn alert", 1'b1, alert_oe)
        `CHK("alert level", 1'b0, alert_o)
        `CHK("hot warn power", 1'b1, pwr_en)
        set_meas(16'sd400, 16'sd192);
        clear();
        expect_rd(8'h79, 16'h0000, "cleared summary");
        `CHK("cleared alert", 1'b0, alert_oe)
    endtask
    // A hot fault holds the output off until the temperature drops below the warning limit.
    task automatic t_hot_fault();
        set_meas(16'sd2001, 16'sd192);
        wait_pwr(1'b0, 10, "hot fault off");
        set_meas(16'sd1800, 16'sd192);
        hold_off(30, "hot fault held");
        expect_rd(8'h7d, 16'h00c0, "hot fault status");
        set_meas(16'sd1700, 16'sd192);
        wait_pwr(1'b1, 20, "hot fault release");
        clear();
    endtask
    // Cold warning, then a cold fault held until above the cold warning limit.
    task automatic t_cold();
        set_meas(-16'sd500, 16'sd192);
        expect_rd(8'h7d, 16'h0020, "cold warn status");
        `CHK("cold warn alert", 1'b1, alert_oe)
        set_meas(-16'sd800, 16'sd192);
        wait_pwr(1'b0, 10, "cold fault off");
        set_meas(-16'sd600, 16'sd192);
        hold_off(30, "cold fault held");
        set_meas(-16'sd400, 16'sd192);
        wait_pwr(1'b1, 20, "cold fault release");
        set_meas(16'sd400, 16'sd192);
        clear();
    endtask
    // Supply warning summary bits, then a supply fault.
    task automatic t_supply();
        set_meas(16'sd400, 16'sd220);
        expect_rd(8'h79, 16'h2001, "supply warn summary");
        expect_rd(8'h7c, 16'h0040, "supply warn status");
        set_meas(16'sd400, 16'sd240);
        wait_pwr(1'b0, 10, "supply fault off");
        expect_rd(8'h7c, 16'h00c0, "supply fault status");
        set_meas(16'sd400, 16'sd192);
        wait_pwr(1'b1, 20, "supply fault release");
        clear();
    endtask
    // Continuous retry with delay code 1 under a standing fault, then the pin turns it off.
    task automatic t_retry();
        int n;
        fls_host_i.wr(8'h50, 16'h00b9);
        set_meas(16'sd2100, 16'sd192);
        wait_pwr(1'b0, 10, "retry first off");
        n = 0;
        while (pwr_en === 1'b0 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK("retry spacing", 1'b1, n >= 18 && n <= 22)
        wait_pwr(1'b0, 10, "retry again off");
        wait_pwr(1'b1, 40, "retry again on");
        ctrl_pin = 1'b0;
        repeat (5) @(negedge clk_sys);
        hold_off(60, "retry abandoned");
        set_meas(16'sd400, 16'sd192);
        ctrl_pin = 1'b1;
        fls_host_i.wr(8'h50, 16'h0080);
        clear();
        wait_pwr(1'b1, 20, "pin on again");
    endtask

    // Main sequence: reset for 12 cycles, then every scenario in turn.
    initial begin
        repeat (12) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (10) @(negedge clk_sys);
        t_defaults();
        t_rw();
        t_hot_warn();
        t_hot_fault();
        t_cold();
        t_supply();
        t_retry();
        final_report();
    end
endmodule
